// *** core/urx_channel.sv ***
// urx_channel: receive path, bit rate divider and registers of one serial channel.
// assumes: Avalon-MM master with waitrequest, ref clock and serial line are async pins.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module urx_channel (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic refClkPin,
    input wire logic serialRxLine,
    input wire logic [3:0] modemInPins,
    output logic [4:0] modemCtrlOut,
    output logic txHoldingEmptyIrq,
    output logic rxBusy
);
    logic refSync;
    logic refPrev_r;
    logic refRise;
    logic rxSync;
    logic rxPrev_r;
    logic tick;
    logic [7:0] divLow_r;
    logic [7:0] divHigh_r;
    logic [7:0] lineFormat_r;
    logic [7:0] irqEnable_r;
    logic [4:0] modemCtrl_r;
    logic [7:0] rxHolding_r;
    logic dataReady_r;
    logic overrun_r;
    logic parityErr_r;
    logic framingErr_r;
    logic [3:0] mstatDelta_r;
    logic [3:0] modemPrev_r;
    logic [3:0] modemSync1_r;
    logic [3:0] modemSync2_r;
    logic [2:0] modemValid_r;
    urx_pkg::urx_state_e state_r;
    logic [3:0] tickCnt_r;
    logic [3:0] bitCnt_r;
    logic [7:0] shifter_r;
    logic parityAcc_r;
    logic stopCnt_r;
    logic xferPulse;
    logic [7:0] xferData;
    logic xferParErr;
    logic xferFrameErr;
    logic ack_r;
    logic rdHolding;
    logic [3:0] wordBits;
    logic bitTime;
    logic [7:0] condByte;

    // number of data bits from the word length code
    function automatic logic [3:0] word_len(input logic [1:0] code);
        word_len = urx_pkg::MIN_DATA_BITS + {2'b00, code};
    endfunction

    urx_sync u_ref_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn(refClkPin),
        .syncOut(refSync)
    );

    urx_sync u_rx_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn(serialRxLine),
        .syncOut(rxSync)
    );

    // edge memories of synchronised pins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            refPrev_r <= 1'b1; // same as synchroniser reset, no false edge
            rxPrev_r <= 1'b1;
        end else begin
            refPrev_r <= refSync;
            rxPrev_r <= rxSync;
        end
    end
    assign refRise = refSync & ~refPrev_r;

    urx_divider u_divider (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .refRise(refRise),
        .divisor({divHigh_r, divLow_r}),
        .tick(tick)
    );

    assign wordBits = word_len(lineFormat_r[urx_pkg::FMT_WLEN_LO +: 2]);
    assign bitTime = tick && (tickCnt_r == urx_pkg::FULL_BIT_TICKS);

    // receive state machine
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= urx_pkg::URX_IDLE;
            tickCnt_r <= 4'h0;
            bitCnt_r <= 4'h0;
            shifter_r <= urx_pkg::BYTE_ZERO;
            parityAcc_r <= 1'b0;
            stopCnt_r <= 1'b0;
            xferPulse <= 1'b0;
            xferData <= urx_pkg::BYTE_ZERO;
            xferParErr <= 1'b0;
            xferFrameErr <= 1'b0;
        end else begin
            xferPulse <= 1'b0;
            case (state_r)
                urx_pkg::URX_IDLE: begin
                    // falling edge out of idle, seen every sys_clk
                    if (rxPrev_r && !rxSync) begin
                        state_r <= urx_pkg::URX_START;
                        tickCnt_r <= 4'h0;
                    end
                end
                urx_pkg::URX_START: begin
                    if (tick) begin
                        if (tickCnt_r == urx_pkg::HALF_BIT_TICKS) begin
                            tickCnt_r <= 4'h0;
                            if (!rxSync) begin
                                state_r <= urx_pkg::URX_DATA;
                                bitCnt_r <= 4'h0;
                                parityAcc_r <= 1'b0;
                                shifter_r <= urx_pkg::BYTE_ZERO;
                            end else begin
                                state_r <= urx_pkg::URX_IDLE;
                            end
                        end else begin
                            tickCnt_r <= tickCnt_r + 4'h1;
                        end
                    end
                end
                urx_pkg::URX_DATA: begin
                    if (tick) begin
                        tickCnt_r <= tickCnt_r + 4'h1;
                    end
                    if (bitTime) begin
                        shifter_r[bitCnt_r[2:0]] <= rxSync;
                        parityAcc_r <= parityAcc_r ^ rxSync;
                        bitCnt_r <= bitCnt_r + 4'h1;
                        if (bitCnt_r + 4'h1 == wordBits) begin
                            if (lineFormat_r[urx_pkg::FMT_PAR_EN]) begin
                                state_r <= urx_pkg::URX_PARITY;
                            end else begin
                                state_r <= urx_pkg::URX_STOP;
                                stopCnt_r <= 1'b0;
                            end
                        end
                    end
                end
                urx_pkg::URX_PARITY: begin
                    if (tick) begin
                        tickCnt_r <= tickCnt_r + 4'h1;
                    end
                    if (bitTime) begin
                        // even select: total ones even; odd select: odd
                        xferParErr <= (parityAcc_r ^ rxSync)
                            != ~lineFormat_r[urx_pkg::FMT_PAR_EVEN];
                        state_r <= urx_pkg::URX_STOP;
                        stopCnt_r <= 1'b0;
                    end
                end
                urx_pkg::URX_STOP: begin
                    if (tick) begin
                        tickCnt_r <= tickCnt_r + 4'h1;
                    end
                    if (bitTime) begin
                        if (!stopCnt_r) begin
                            xferFrameErr <= !rxSync;
                            xferData <= shifter_r;
                            if (!lineFormat_r[urx_pkg::FMT_PAR_EN]) begin
                                xferParErr <= 1'b0;
                            end
                        end
                        // second stop bit checked only when selected
                        if (lineFormat_r[urx_pkg::FMT_STOP] && !stopCnt_r && rxSync) begin
                            stopCnt_r <= 1'b1;
                        end else begin
                            if (stopCnt_r) begin
                                xferFrameErr <= xferFrameErr | !rxSync;
                            end
                            xferPulse <= 1'b1;
                            state_r <= urx_pkg::URX_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= urx_pkg::URX_IDLE;
                end
            endcase
        end
    end
    assign rxBusy = (state_r != urx_pkg::URX_IDLE);

    // holding buffer keeps its contents across reset
    always_ff @(posedge sys_clk) begin
        if (xferPulse) begin
            rxHolding_r <= xferData;
        end
    end

    // configuration registers untouched by reset
    always_ff @(posedge sys_clk) begin
        if (avs_write && ack_r) begin
            case (avs_address)
                urx_pkg::REG_DIV_LOW: divLow_r <= avs_writedata[7:0];
                urx_pkg::REG_DIV_HIGH: divHigh_r <= avs_writedata[7:0];
                urx_pkg::REG_LINE_FORMAT: lineFormat_r <= avs_writedata[7:0];
                default: begin
                end
            endcase
        end
    end

    // reset-cleared control registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqEnable_r <= urx_pkg::BYTE_ZERO;
            modemCtrl_r <= 5'h00;
        end else if (avs_write && ack_r) begin
            if (avs_address == urx_pkg::REG_IRQ_ENABLE) begin
                irqEnable_r <= avs_writedata[7:0];
            end
            if (avs_address == urx_pkg::REG_MODEM_CTRL) begin
                modemCtrl_r <= avs_writedata[4:0];
            end
        end
    end
    assign modemCtrlOut = modemCtrl_r;
    // transmitter is idle here, so holding-empty stays set
    assign txHoldingEmptyIrq = irqEnable_r[urx_pkg::IRQ_EN_HOLD_EMPTY];

    assign rdHolding = avs_read && ack_r && (avs_address == urx_pkg::REG_RX_HOLDING);

    // line condition flags; a new event wins over a clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataReady_r <= 1'b0;
            overrun_r <= 1'b0;
            parityErr_r <= 1'b0;
            framingErr_r <= 1'b0;
        end else begin
            if (xferPulse) begin
                dataReady_r <= 1'b1;
            end else if (rdHolding) begin
                dataReady_r <= 1'b0;
            end
            if (xferPulse && dataReady_r && !rdHolding) begin
                overrun_r <= 1'b1;
            end else if (avs_read && ack_r && avs_address == urx_pkg::REG_LINE_COND) begin
                overrun_r <= 1'b0;
            end
            if (xferPulse && xferParErr) begin
                parityErr_r <= 1'b1;
            end else if (avs_read && ack_r && avs_address == urx_pkg::REG_LINE_COND) begin
                parityErr_r <= 1'b0;
            end
            if (xferPulse && xferFrameErr) begin
                framingErr_r <= 1'b1;
            end else if (avs_read && ack_r && avs_address == urx_pkg::REG_LINE_COND) begin
                framingErr_r <= 1'b0;
            end
        end
    end

    // modem status: deltas cleared by reset and by reading
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            modemSync1_r <= 4'h0;
            modemSync2_r <= 4'h0;
            modemPrev_r <= 4'h0;
            modemValid_r <= 3'h0;
            mstatDelta_r <= urx_pkg::MSTAT_DELTA_RESET;
        end else begin
            modemSync1_r <= modemInPins;
            modemSync2_r <= modemSync1_r;
            modemPrev_r <= modemSync2_r;
            // no delta until the pipeline holds real pin levels
            modemValid_r <= {modemValid_r[1:0], 1'b1};
            if (modemValid_r[2] && modemSync2_r != modemPrev_r) begin
                mstatDelta_r <= mstatDelta_r | (modemSync2_r ^ modemPrev_r);
            end else if (avs_read && ack_r && avs_address == urx_pkg::REG_MODEM_STAT) begin
                mstatDelta_r <= urx_pkg::MSTAT_DELTA_RESET;
            end
        end
    end

    // holding-empty and all-empty read set after reset
    always_comb begin
        condByte = urx_pkg::BYTE_ZERO;
        condByte[urx_pkg::COND_READY] = dataReady_r;
        condByte[urx_pkg::COND_OVERRUN] = overrun_r;
        condByte[urx_pkg::COND_PARITY] = parityErr_r;
        condByte[urx_pkg::COND_FRAMING] = framingErr_r;
        condByte[urx_pkg::COND_HOLD_EMPTY] = urx_pkg::COND_RESET[urx_pkg::COND_HOLD_EMPTY];
        condByte[urx_pkg::COND_ALL_EMPTY] = urx_pkg::COND_RESET[urx_pkg::COND_ALL_EMPTY];
    end

    // bus answer: one wait cycle, then ack with registered read data
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            avs_readdata <= urx_pkg::WORD_ZERO;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
            if (avs_read && !ack_r) begin
                case (avs_address)
                    urx_pkg::REG_RX_HOLDING: avs_readdata <= {24'h00_0000, rxHolding_r};
                    urx_pkg::REG_IRQ_ENABLE: avs_readdata <= {24'h00_0000, irqEnable_r};
                    urx_pkg::REG_DIV_LOW: avs_readdata <= {24'h00_0000, divLow_r};
                    urx_pkg::REG_DIV_HIGH: avs_readdata <= {24'h00_0000, divHigh_r};
                    urx_pkg::REG_LINE_FORMAT: avs_readdata <= {24'h00_0000, lineFormat_r};
                    urx_pkg::REG_MODEM_CTRL: avs_readdata <= {27'h000_0000, modemCtrl_r};
                    urx_pkg::REG_LINE_COND: avs_readdata <= {24'h00_0000, condByte};
                    urx_pkg::REG_MODEM_STAT: avs_readdata <= {24'h00_0000, modemSync2_r, mstatDelta_r};
                    default: avs_readdata <= urx_pkg::WORD_ZERO;
                endcase
            end
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
endmodule // urx_channel

// *** core/urx_pkg.sv ***
// urx_pkg: constants for the serial receive channel, its divider and its registers.
// assumes: one 100 MHz clock, Avalon-MM register access, one reference-clock pin.
// What this block does
// - a high serial input is idle; watch for a falling edge out of idle
// - on the edge clear the counter and count sixteen-times ticks to seven and a half; the code samples on the eighth tick (count 7)
// - accept the start bit only if still low at mid-bit, else drop it
// - format bits select word length, stop bits, parity enable and parity polarity
// - moving a character to the holding buffer sets data ready; reading it clears it
// - a new character before the old one is read sets overrun
// - with parity enabled, a wrong parity bit sets the parity error flag
// - a low stop bit sets the framing error flag
// - start edge is seen within one sixteen-times tick of the line falling
// - reference clock divides by the sixteen-bit divisor; one is the fastest rate
// - the divisor range gives standard rates 50 bps to 38.5 kbps at usual clocks
// - master reset restarts the receive clock counters
// - reset clears line status except both transmit-empty flags, which it sets; clears modem
// - reset leaves the format register, divisor latches and the receive holding buffer untouched
// - after reset the channel is idle but starts on the next falling edge, using the kept format and divisor
// - the set holding-empty flag raises an interrupt once the host enables it
// - after reset line status bits 5 and 6 read high, the rest low
// - after reset modem status bits 0 to 3 read low, 4 to 7 follow pins
package urx_pkg;
    // register word offsets (byte address = 4 x index)
    localparam logic [2:0] REG_RX_HOLDING = 3'h0;
    localparam logic [2:0] REG_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] REG_DIV_LOW = 3'h2;
    localparam logic [2:0] REG_DIV_HIGH = 3'h3;
    localparam logic [2:0] REG_LINE_FORMAT = 3'h4;
    localparam logic [2:0] REG_MODEM_CTRL = 3'h5;
    localparam logic [2:0] REG_LINE_COND = 3'h6;
    localparam logic [2:0] REG_MODEM_STAT = 3'h7;
    // line format fields
    localparam int FMT_WLEN_LO = 0;
    localparam int FMT_STOP = 2;
    localparam int FMT_PAR_EN = 3;
    localparam int FMT_PAR_EVEN = 4;
    // line condition fields
    localparam int COND_READY = 0;
    localparam int COND_OVERRUN = 1;
    localparam int COND_PARITY = 2;
    localparam int COND_FRAMING = 3;
    localparam int COND_HOLD_EMPTY = 5;
    localparam int COND_ALL_EMPTY = 6;
    localparam int IRQ_EN_HOLD_EMPTY = 1;
    localparam logic [7:0] COND_RESET = 8'h60;
    localparam logic [3:0] MSTAT_DELTA_RESET = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // sixteen-times tick timing
    localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
    localparam logic [3:0] FULL_BIT_TICKS = 4'hf;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [15:0] DIV_ONE = 16'h0001;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    typedef enum logic [2:0] {URX_IDLE, URX_START, URX_DATA, URX_PARITY, URX_STOP} urx_state_e;
endpackage

// *** core/urx_sync.sv ***
// urx_sync: two-flip-flop synchroniser for one asynchronous level.
// assumes: sys_clk domain, asynchronous active-low reset.
`timescale 1ns/1ps
module urx_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_r;
    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= 1'b1;
            syncOut <= 1'b1;
        end else begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule // urx_sync

// *** core/urx_divider.sv ***
// urx_divider: sixteen-bit divider making one sixteen-times tick per divisor ref edges.
// assumes: refClk already synchronised, rising edges counted.
`timescale 1ns/1ps
module urx_divider (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic refRise,
    input wire logic [15:0] divisor,
    output logic tick
);
    logic [15:0] count_r;
    // count ref edges; divisor 0 treated as 1
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= urx_pkg::DIV_ONE;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (refRise) begin
                if (count_r >= divisor) begin
                    count_r <= urx_pkg::DIV_ONE;
                    tick <= 1'b1;
                end else begin
                    count_r <= count_r + urx_pkg::DIV_ONE;
                end
            end
        end
    end
endmodule // urx_divider

// *** bench/urx_channel_properties.sv ***
// urx_channel_properties: port-level checks of the serial receive channel.
// assumes: bound to urx_channel, one sys_clk domain, rst_n active low.
`timescale 1ns/1ps
module urx_channel_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic refClkPin,
    input wire logic serialRxLine,
    input wire logic [3:0] modemInPins,
    input wire logic [4:0] modemCtrlOut,
    input wire logic txHoldingEmptyIrq,
    input wire logic rxBusy
);
    logic wrAck;
    logic rdAck;
    logic [4:0] ctrlData;
    // completed bus cycles and the modem control field of a write
    assign wrAck = avs_write && !avs_waitrequest;
    assign rdAck = avs_read && !avs_waitrequest;
    assign ctrlData = avs_writedata[4:0];
    default clocking propClk @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    AST_BUS_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    AST_COND_FIXED: assert property (rdAck && avs_address == urx_pkg::REG_LINE_COND
        |-> avs_readdata[31:4] == 28'h000_0006) else $error("status fixed bits wrong");
    AST_IRQ_ON: assert property (wrAck && avs_address == urx_pkg::REG_IRQ_ENABLE
        && avs_writedata[1] |-> ##[1:2] txHoldingEmptyIrq) else $error("irq not raised");
    AST_IRQ_OFF: assert property (wrAck && avs_address == urx_pkg::REG_IRQ_ENABLE
        && !avs_writedata[1] |-> ##[1:2] !txHoldingEmptyIrq) else $error("irq not dropped");
    AST_MODEM_CTRL: assert property (wrAck && avs_address == urx_pkg::REG_MODEM_CTRL
        |=> modemCtrlOut == $past(ctrlData)) else $error("modem control not written");
    AST_RESET_IDLE: assert property ($rose(rst_n)
        |-> !rxBusy && modemCtrlOut == 5'h00 && !txHoldingEmptyIrq) else $error("not idle");
    AST_START_SEEN: assert property ($fell(serialRxLine) && !rxBusy
        ##1 !serialRxLine [*8] |-> ##[0:40] rxBusy) else $error("start edge missed");
    AST_LINE_IDLE: assert property ((!rxBusy && serialRxLine) [*8] |=> !rxBusy)
        else $error("receiver started on an idle line");
    AST_START_HOLD: assert property ($rose(rxBusy) |-> rxBusy [*8])
        else $error("start abandoned before mid-bit");
endmodule // urx_channel_properties

bind urx_channel urx_channel_properties u_props (.sys_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .refClkPin, .serialRxLine,
    .modemInPins, .modemCtrlOut, .txHoldingEmptyIrq, .rxBusy);

// *** bench/urx_tx_model.sv ***
// urx_tx_model: behavioural remote transmitter driving the serial line.
// assumes: caller passes the bit time in ns matching the programmed divisor.
`timescale 1ns/1ps
module urx_tx_model (
    output logic serialLine
);
    // line rests high between frames
    initial serialLine = 1'h1;
    // one frame: start, data lsb first, optional parity, stop bits
    task automatic send(input logic [7:0] fmt, input int bitNs, input logic [7:0] data,
                        input logic badPar, input logic badStop);
        int nBits;
        logic par;
        nBits = 5 + int'(fmt[1:0]);
        par = ^(data & (8'hff >> (8 - nBits))) ^ ~fmt[4] ^ badPar;
        #1;
        serialLine = 1'h0;
        #(bitNs);
        for (int i = 0; i < nBits; i++) begin
            serialLine = data[i];
            #(bitNs);
        end
        if (fmt[3]) begin
            serialLine = par;
            #(bitNs);
        end
        serialLine = ~badStop;
        #(bitNs);
        serialLine = 1'h1;
        if (fmt[2]) #(bitNs);
    endtask
    // short low pulse that must not become a character
    task automatic glitch(input int lowNs);
        #1;
        serialLine = 1'h0;
        #(lowNs);
        serialLine = 1'h1;
    endtask
endmodule // urx_tx_model

// *** bench/tb_uart_receiver_baud_reset.sv ***
// tb_uart_receiver_baud_reset: table of frames, then overrun, noise, reset and irq cases.
// assumes: urx_channel with urx_tx_model on the line and a 100 ns reference clock.
`timescale 1ns/1ps
module tb_uart_receiver_baud_reset;
    typedef struct packed {
        logic [7:0] fmt;
        logic [7:0] div;
        logic [7:0] data;
        logic badPar;
        logic badStop;
    } urx_case_s;
    logic sys_clk;
    logic rst_n;
    logic [2:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic refClkPin;
    logic serialRxLine;
    logic [4:0] modemCtrlOut;
    logic txHoldingEmptyIrq;
    logic rxBusy;
    logic [7:0] got;
    int numErrors = 0;
    int nChecks = 0;
    int cycles = 0;
    urx_case_s rows [8];
    urx_case_s row;
    // system clock and an unrelated reference clock
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        refClkPin = 1'h0;
        #13;
        forever #50 refClkPin = ~refClkPin;
    end
    urx_channel uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .refClkPin(refClkPin), .serialRxLine(serialRxLine), .modemInPins(4'ha),
        .modemCtrlOut(modemCtrlOut), .txHoldingEmptyIrq(txHoldingEmptyIrq), .rxBusy(rxBusy));
    urx_tx_model txm (.serialLine(serialRxLine));
    // verdict and end of run
    task automatic completeRun();
        if (numErrors == 0 && nChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic report(input string msg);
        numErrors++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask
    task automatic checkByte(input logic [7:0] act, input logic [7:0] exp, input string what);
        nChecks++;
        if (act !== exp) report($sformatf("%s got %h expected %h", what, act, exp));
    endtask
    // one bus cycle, request held until waitrequest is sampled low
    task automatic busCycle(input logic wr, input logic [2:0] addr, input logic [7:0] wdata);
        @(posedge sys_clk);
        avs_address <= addr;
        avs_writedata <= {24'h00_0000, wdata};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'h0);
        got = avs_readdata[7:0];
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    // wait for the receiver to finish before touching control registers
    task automatic waitIdle();
        int n;
        n = 0;
        while (rxBusy !== 1'h0 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 5000) report("receiver stuck busy");
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            report("run timed out");
            completeRun();
        end
    end
    initial begin
        rows = '{'{8'h00, 8'h01, 8'h15, 1'h0, 1'h0}, '{8'h05, 8'h01, 8'h2a, 1'h0, 1'h0},
            '{8'h0a, 8'h01, 8'h55, 1'h0, 1'h0}, '{8'h1b, 8'h02, 8'ha5, 1'h0, 1'h0},
            '{8'h1b, 8'h01, 8'h3c, 1'h1, 1'h0}, '{8'h03, 8'h01, 8'h81, 1'h0, 1'h1},
            '{8'h0f, 8'h01, 8'h7e, 1'h0, 1'h1}, '{8'h13, 8'h01, 8'hff, 1'h1, 1'h0}};
        rst_n = 1'h0;
        avs_address = 3'h0;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0000_0000;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'h1;
        busCycle(1'h0, urx_pkg::REG_LINE_COND, 8'h00);
        checkByte(got, urx_pkg::COND_RESET, "status after reset");
        busCycle(1'h0, urx_pkg::REG_MODEM_STAT, 8'h00);
        checkByte(got, 8'ha0, "modem status after reset");
        checkByte({3'h0, modemCtrlOut}, 8'h00, "modem control after reset");
        // table of frames across formats, errors and divisors
        for (int k = 0; k < 8; k++) begin
            row = rows[k];
            busCycle(1'h1, urx_pkg::REG_DIV_LOW, row.div);
            busCycle(1'h1, urx_pkg::REG_DIV_HIGH, 8'h00);
            busCycle(1'h1, urx_pkg::REG_LINE_FORMAT, row.fmt);
            txm.send(row.fmt, 1600 * int'(row.div), row.data, row.badPar, row.badStop);
            waitIdle();
            busCycle(1'h0, urx_pkg::REG_LINE_COND, 8'h00);
            checkByte(got, {4'h6, row.badStop, row.badPar & row.fmt[3], 2'h1}, "flags");
            busCycle(1'h0, urx_pkg::REG_RX_HOLDING, 8'h00);
            checkByte(got, row.data & (8'hff >> (2'h3 - row.fmt[1:0])), "data");
            busCycle(1'h0, urx_pkg::REG_LINE_COND, 8'h00);
            checkByte(got, urx_pkg::COND_RESET, "ready after read");
        end
        // two frames unread, then a noise pulse
        txm.send(8'h13, 1600, 8'h11, 1'h0, 1'h0);
        waitIdle();
        txm.send(8'h13, 1600, 8'h22, 1'h0, 1'h0);
        waitIdle();
        busCycle(1'h0, urx_pkg::REG_LINE_COND, 8'h00);
        checkByte(got, 8'h63, "overrun flags");
        busCycle(1'h0, urx_pkg::REG_RX_HOLDING, 8'h00);
        checkByte(got, 8'h22, "newest frame kept");
        txm.glitch(400);
        waitIdle();
        busCycle(1'h0, urx_pkg::REG_LINE_COND, 8'h00);
        checkByte(got, urx_pkg::COND_RESET, "noise gave no frame");
        // reset in mid-run keeps format, divisor and holding buffer
        busCycle(1'h1, urx_pkg::REG_MODEM_CTRL, 8'h1f);
        @(posedge sys_clk);
        checkByte({3'h0, modemCtrlOut}, 8'h1f, "modem control written");
        rst_n <= 1'h0;
        repeat (50) @(posedge sys_clk);
        checkByte({2'h0, modemCtrlOut, rxBusy}, 8'h00, "outputs in reset");
        rst_n <= 1'h1;
        busCycle(1'h0, urx_pkg::REG_LINE_FORMAT, 8'h00);
        checkByte(got, 8'h13, "format kept");
        busCycle(1'h0, urx_pkg::REG_DIV_LOW, 8'h00);
        checkByte(got, 8'h01, "divisor low kept");
        busCycle(1'h0, urx_pkg::REG_DIV_HIGH, 8'h00);
        checkByte(got, 8'h00, "divisor high kept");
        busCycle(1'h0, urx_pkg::REG_RX_HOLDING, 8'h00);
        checkByte(got, 8'h22, "holding kept");
        busCycle(1'h0, urx_pkg::REG_LINE_COND, 8'h00);
        checkByte(got, urx_pkg::COND_RESET, "status after second reset");
        // holding-empty interrupt follows its enable
        busCycle(1'h1, urx_pkg::REG_IRQ_ENABLE, 8'h02);
        repeat (2) @(posedge sys_clk);
        checkByte({7'h00, txHoldingEmptyIrq}, 8'h01, "irq after enable");
        busCycle(1'h1, urx_pkg::REG_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge sys_clk);
        checkByte({7'h00, txHoldingEmptyIrq}, 8'h00, "irq after disable");
        txm.send(8'h13, 1600, 8'h5a, 1'h0, 1'h0);
        waitIdle();
        busCycle(1'h0, urx_pkg::REG_RX_HOLDING, 8'h00);
        checkByte(got, 8'h5a, "frame after reset");
        completeRun();
    end
endmodule // tb_uart_receiver_baud_reset
